/* pkg/iowd_defines.svh */
/*
 * Constants for the I/O pin watchdog: time-out default, clock rate, pin count.
 * Assumes a 50 MHz system clock; included by bare name.
 */
`ifndef IOWD_DEFINES_SVH
`define IOWD_DEFINES_SVH

// ----------------------------------------
// timing
// ----------------------------------------
`define IOWD_CLK_PERIOD_NS 32'd20
`define IOWD_BITE_A_DEFAULT_NS 32'd5000000
`define IOWD_BITE_A_DEFAULT_CYC (`IOWD_BITE_A_DEFAULT_NS / `IOWD_CLK_PERIOD_NS)

// ----------------------------------------
// pins
// ----------------------------------------
`define IOWD_NUM_PINS 8

`endif

/* pkg/iowd_pkg.sv */
/*
 * Types for the I/O pin watchdog.
 * Assumes the defines header is compiled first.
 */
`include "iowd_defines.svh"

package iowd_pkg;
    typedef enum logic {
        IOWD_ARMED,
        IOWD_BITTEN
    } iowd_state_t;

    // one group of pin drive signals
    typedef struct packed {
        logic [`IOWD_NUM_PINS-1:0] out;
        logic [`IOWD_NUM_PINS-1:0] oe;
    } iowd_pins_t;
endpackage : iowd_pkg

/* hdl/iowd_timer.sv */
/*
 * Time-out counter in nanoseconds, restarted by each service pulse.
 * Assumes the programmed time-out is held stable by the host.
 */
`timescale 1ns/1ps
`default_nettype none
`include "iowd_defines.svh"

module iowd_timer (
    input wire logic mclk_i,          // system clock
    input wire logic rst_i,           // sync reset, high
    input wire logic service_i,       // restart pulse
    input wire logic [31:0] limit_i,  // time-out in ns
    output logic expired_o            // pulse: gap exceeded limit
);
    logic [31:0] elapsed_q;
    logic [31:0] elapsed_d;
    logic expired_q;
    logic expired_d;

    always_comb begin
        elapsed_d = elapsed_q;
        expired_d = 1'b0;
        // gap at this edge is elapsed plus one period; 33 bits so it never wraps
        if (({1'b0, elapsed_q} + {1'b0, `IOWD_CLK_PERIOD_NS}) > {1'b0, limit_i}) begin
            expired_d = 1'b1;
            elapsed_d = 32'h0;
        end else if (service_i) begin
            elapsed_d = 32'h0;
        end else begin
            elapsed_d = elapsed_q + `IOWD_CLK_PERIOD_NS;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            elapsed_q <= 32'h0;
            expired_q <= 1'b0;
        end else begin
            elapsed_q <= elapsed_d;
            expired_q <= expired_d;
        end
    end

    assign expired_o = expired_q;
endmodule : iowd_timer

`default_nettype wire

/* hdl/iowd_top.sv */
/*
 * I/O pin watchdog: sits between the function units and the pin drivers.
 * Assumes the host pulses a service strobe on each full output write and
 * that pins have external or pad pull-ups requested through pullup_o.
 */
`timescale 1ns/1ps
`default_nettype none
`include "iowd_defines.svh"

module iowd_top #(
    parameter bit WD_PRESENT = 1'b1   // build option
) (
    input wire logic mclk_i,                           // system clock
    input wire logic rst_i,                            // sync reset, high
    input wire logic service_i,                        // full output write strobe
    input wire logic bite_a_we_i,                      // write the time-out
    input wire logic [31:0] bite_a_i,                  // time-out value in ns
    input wire logic flag_clr_i,                       // host writes false to flag
    input wire iowd_pkg::iowd_pins_t func_i,           // function unit drive
    input wire logic [`IOWD_NUM_PINS-1:0] pin_in_i,    // pad input levels
    output logic [`IOWD_NUM_PINS-1:0] pin_in_o,        // pad levels to units
    output logic [`IOWD_NUM_PINS-1:0] pin_out_o,       // pad output value
    output logic [`IOWD_NUM_PINS-1:0] pin_oe_o,        // pad drive enable
    output logic [`IOWD_NUM_PINS-1:0] pullup_o,        // pad pull-up request
    output logic [31:0] bite_a_o,                      // time-out readback
    output logic present_o,                            // watchdog built in
    output logic has_bitten_o                          // bite flag
);
    // ----------------------------------------
    // time-out register
    // ----------------------------------------
    logic [31:0] bite_a_q;
    logic [31:0] bite_a_d;

    always_comb begin
        bite_a_d = bite_a_q;
        if (bite_a_we_i) begin
            bite_a_d = bite_a_i;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            bite_a_q <= `IOWD_BITE_A_DEFAULT_NS;
        end else begin
            bite_a_q <= bite_a_d;
        end
    end

    // ----------------------------------------
    // timer
    // ----------------------------------------
    logic expired;

    iowd_timer u_timer (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .service_i(service_i),
        .limit_i(bite_a_q),
        .expired_o(expired)
    );

    // ----------------------------------------
    // bite state
    // ----------------------------------------
    iowd_pkg::iowd_state_t state_q;
    iowd_pkg::iowd_state_t state_d;

    always_comb begin
        state_d = state_q;
        case (state_q)
            iowd_pkg::IOWD_ARMED: begin
                if (WD_PRESENT && expired) begin
                    state_d = iowd_pkg::IOWD_BITTEN;
                end
            end
            iowd_pkg::IOWD_BITTEN: begin
                // service alone never recovers; set wins over clear
                if (flag_clr_i && !expired) begin
                    state_d = iowd_pkg::IOWD_ARMED;
                end else begin
                    state_d = iowd_pkg::IOWD_BITTEN;
                end
            end
            default: begin
                state_d = iowd_pkg::IOWD_BITTEN;
            end
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            state_q <= iowd_pkg::IOWD_ARMED;
        end else begin
            state_q <= state_d;
        end
    end

    // ----------------------------------------
    // pin mux
    // ----------------------------------------
    iowd_pkg::iowd_pins_t pins_q;
    iowd_pkg::iowd_pins_t pins_d;
    logic bitten;

    assign bitten = (state_q == iowd_pkg::IOWD_BITTEN);

    // units keep their drive untouched; only the pad path is cut
    always_comb begin
        if (bitten) begin
            pins_d.out = '0;
            pins_d.oe = '0;
        end else begin
            pins_d = func_i;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            pins_q <= '0;
        end else begin
            pins_q <= pins_d;
        end
    end

    assign pin_out_o = pins_q.out;
    assign pin_oe_o = pins_q.oe;
    assign pullup_o = ~pins_q.oe;
    assign pin_in_o = pin_in_i;
    assign bite_a_o = bite_a_q;
    assign present_o = WD_PRESENT;
    assign has_bitten_o = bitten;
endmodule : iowd_top

`default_nettype wire

/* tb/iowd_chk_assertions.sv */
/* checker for iowd_top, attached by the bind at the foot.
   assumes one clock and a synchronous active-high reset. */
`timescale 1ns/1ps
`default_nettype none
module iowd_chk (
    input wire logic mclk_i, // clock
    input wire logic rst_i, // reset
    input wire logic service_i, // service
    input wire logic bite_a_we_i, // limit write
    input wire logic [31:0] bite_a_i, // new limit
    input wire logic flag_clr_i, // flag clear
    input wire iowd_pkg::iowd_pins_t func_i, // unit drive
    input wire logic [7:0] pin_out_o, // pad value
    input wire logic [7:0] pin_oe_o, // pad enable
    input wire logic [7:0] pullup_o, // pull-up
    input wire logic [31:0] bite_a_o, // limit
    input wire logic has_bitten_o // flag
);
    // ---
    // cycles since last service
    // ---
    logic [31:0] idle_q, idle_d;
    always_comb idle_d = (rst_i || service_i) ? 32'h0 : idle_q + 32'h1;
    always_ff @(posedge mclk_i) idle_q <= idle_d;
    default clocking @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    sequence s_armed; !rst_i && !has_bitten_o ##1 !has_bitten_o; endsequence
    sequence s_srv; service_i [*3]; endsequence
    property p_pull; pullup_o == ~pin_oe_o; endproperty
    property p_follow; s_armed |-> {pin_out_o, pin_oe_o} == $past(func_i); endproperty
    property p_safe; has_bitten_o [*2] |-> pin_oe_o == 8'h0; endproperty
    property p_hold; has_bitten_o && !flag_clr_i |=> has_bitten_o; endproperty
    property p_clear; s_srv ##0 (has_bitten_o && flag_clr_i) |=> !has_bitten_o; endproperty
    property p_rel; $fell(has_bitten_o) |-> $past(flag_clr_i); endproperty
    // four cycles of slack over the expected bite latency
    property p_late; idle_q == bite_a_o / 32'h14 + 32'h6 |-> has_bitten_o; endproperty
    property p_lim; bite_a_we_i |=> bite_a_o == $past(bite_a_i); endproperty
    a_pull: assert property (p_pull) else $error("pull-up wrong");
    a_follow: assert property (p_follow) else $error("pins not routed");
    a_safe: assert property (p_safe) else $error("pin driven while bitten");
    a_hold: assert property (p_hold) else $error("flag dropped");
    a_clear: assert property (p_clear) else $error("flag not cleared");
    a_rel: assert property (p_rel) else $error("flag fell alone");
    a_late: assert property (p_late) else $error("no bite");
    a_lim: assert property (p_lim) else $error("limit not written");
endmodule : iowd_chk
bind iowd_top iowd_chk iowd_chk_inst (.mclk_i(mclk_i), .rst_i(rst_i), .service_i(service_i),
    .bite_a_we_i(bite_a_we_i), .bite_a_i(bite_a_i), .flag_clr_i(flag_clr_i), .func_i(func_i),
    .pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o), .pullup_o(pullup_o), .bite_a_o(bite_a_o),
    .has_bitten_o(has_bitten_o));
`default_nettype wire

/* tb/iowd_top_tb_top.sv */
/* bench for iowd_top: drives on the falling edge, flag changes scored from a queue.
   assumes the checker is bound in. */
`timescale 1ns/1ps
`default_nettype none
`include "iowd_defines.svh"
module iowd_top_tb_top;
    logic mclk_i = 1'h0, rst_i = 1'h1, service_i = 1'h0, bite_a_we_i = 1'h0, flag_clr_i = 1'h0;
    logic [31:0] bite_a_i = 32'hc8, bite_a_o;
    iowd_pkg::iowd_pins_t func_i = 16'h0;
    logic [7:0] pin_in_i = 8'h0, pin_in_o, pin_out_o, pin_oe_o, pullup_o;
    logic present_o, has_bitten_o, seen_q = 1'h0, follow = 1'h0;
    int errors = 0, checks_done = 0, seed = 32'hede3cedc, per = 1, k = 0;
    logic exp_q[$];
    iowd_top iowd_top_inst (.mclk_i(mclk_i), .rst_i(rst_i), .service_i(service_i),
        .bite_a_we_i(bite_a_we_i), .bite_a_i(bite_a_i), .flag_clr_i(flag_clr_i),
        .func_i(func_i), .pin_in_i(pin_in_i), .pin_in_o(pin_in_o), .pin_out_o(pin_out_o),
        .pin_oe_o(pin_oe_o), .pullup_o(pullup_o), .bite_a_o(bite_a_o),
        .present_o(present_o), .has_bitten_o(has_bitten_o));
    initial forever #10 mclk_i = ~mclk_i;
    task automatic check(input logic [31:0] s, e, input string n);
        checks_done++;
        if (s !== e) begin
            errors++;
            $display("MISMATCH %s exp %h seen %h", n, e, s);
        end
    endtask : check
    task automatic finish_test;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : finish_test
    task automatic step(input int n);
        repeat (n) begin
            @(negedge mclk_i);
            if (follow) check({pin_out_o, pin_oe_o}, func_i, "pins");
            check(pin_in_o, pin_in_i, "pin_in");
            k++;
            service_i = (k % per == 0);
            func_i = 16'($random(seed));
            pin_in_i = 8'($random(seed));
        end
    endtask : step
    // ---
    // flag scoreboard and watchdog (run is about 196 cycles)
    // ---
    always @(negedge mclk_i) if (!rst_i && has_bitten_o !== seen_q) begin
        seen_q = has_bitten_o;
        check(has_bitten_o, exp_q.size() ? exp_q.pop_front() : ~has_bitten_o, "flag");
    end
    initial begin
        #40000;
        errors++;
        finish_test();
    end
    initial begin
        repeat (16) @(negedge mclk_i);
        check(bite_a_o, `IOWD_BITE_A_DEFAULT_NS, "default");
        rst_i = 1'h0;
        bite_a_we_i = 1'h1;
        @(negedge mclk_i);
        bite_a_we_i = 1'h0;
        check(pullup_o, 8'hff, "pullup");
        check(present_o, 1'h1, "present");
        check(bite_a_o, 32'hc8, "limit");
        step(2);
        follow = 1'h1;
        per = 10;
        step(80); // gap equal to the limit must not bite
        follow = 1'h0;
        per = 11;
        exp_q.push_back(1'h1);
        step(36);
        check(pin_oe_o, 8'h0, "oe");
        per = 999;
        step(25);
        per = 3;
        step(10);
        check(has_bitten_o, 1'h1, "held");
        per = 1;
        step(3);
        flag_clr_i = 1'h1;
        exp_q.push_back(1'h0);
        step(1);
        flag_clr_i = 1'h0;
        per = 5;
        step(2);
        follow = 1'h1;
        step(20);
        check(32'(exp_q.size()), 32'h0, "notes");
        finish_test();
    end
endmodule : iowd_top_tb_top
`default_nettype wire
